// >>> hdl/hpcd_pkg.sv
package hpcd_pkg;

   // access-select encodings
   localparam logic [1:0] SEL_CONTROL  = 2'h0;
   localparam logic [1:0] SEL_DATA_INC = 2'h1;
   localparam logic [1:0] SEL_ADDRESS  = 2'h2;
   localparam logic [1:0] SEL_DATA_FIX = 2'h3;

   // widths
   localparam int HALF_W = 16;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 32;
   localparam int PIN_W  = 23;

   // host_port_control field positions and reset value
   localparam int HWORD_ORDER_BIT  = 0;
   localparam int DUAL_MODE_BIT    = 2;
   localparam int ADDR_SELECT_BIT  = 3;
   localparam int HWORD_STATUS_BIT = 8;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;

   // write path buffer depth
   localparam int FIFO_DEPTH = 32;

   // access sequencer states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_STROBE = 2'h1,
      ST_PUSH   = 2'h3,
      ST_FETCH  = 2'h2
   } hpcd_state_type;

endpackage

// >>> hdl/hpcd_stream_if.sv
interface hpcd_stream_if #(
   parameter int WIDTH = 64
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   // producing end
   modport src (
      output valid,
      output data,
      input  ready
   );

   // consuming end
   modport snk (
      input  valid,
      input  data,
      output ready
   );
endinterface

// >>> hdl/hpcd_sync.sv
module hpcd_sync #(
   parameter int WIDTH = 23
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             nrst_i,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // two flops; the first stage feeds nothing but the second
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1_reg <= '1;
         stage2_reg <= '1;
      end else begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_o = stage2_reg;

endmodule

// >>> hdl/hpcd_fifo.sv
module hpcd_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic  ref_clk_i,
   input  wire logic  nrst_i,
   // fill and drain sides
   hpcd_stream_if.snk in_port,
   hpcd_stream_if.src out_port
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_reg;
   logic [AW-1:0]    wptr_next;
   logic [AW-1:0]    rptr_reg;
   logic [AW-1:0]    rptr_next;
   logic [AW:0]      cnt_reg;
   logic [AW:0]      cnt_next;
   logic             ovalid_reg;
   logic             ovalid_next;
   logic [WIDTH-1:0] odata_reg;
   logic [WIDTH-1:0] odata_next;
   logic             push;
   logic             pop;

   // full means no room in the array; the output register is extra slack
   assign in_port.ready = (cnt_reg != (AW+1)'(DEPTH));
   assign push          = in_port.valid && in_port.ready;
   assign pop           = (cnt_reg != '0) && (!ovalid_reg || out_port.ready);

   // pointer, count and output stage next values
   always_comb begin
      wptr_next   = push ? AW'(wptr_reg + 1'b1) : wptr_reg;
      rptr_next   = pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
      cnt_next    = (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
      ovalid_next = ovalid_reg;
      odata_next  = odata_reg;
      if (pop) begin
         ovalid_next = 1'b1;
         odata_next  = mem[rptr_reg];
      end else if (out_port.ready) begin
         ovalid_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wptr_reg   <= '0;
         rptr_reg   <= '0;
         cnt_reg    <= '0;
         ovalid_reg <= 1'b0;
         odata_reg  <= '0;
      end else begin
         wptr_reg   <= wptr_next;
         rptr_reg   <= rptr_next;
         cnt_reg    <= cnt_next;
         ovalid_reg <= ovalid_next;
         odata_reg  <= odata_next;
      end
   end

   // storage array, no reset needed
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wptr_reg] <= in_port.data;
      end
   end

   assign out_port.valid = ovalid_reg;
   assign out_port.data  = odata_reg;

endmodule

// >>> hdl/hpcd_host_port.sv
module hpcd_host_port #(
   parameter int FIFO_DEPTH = hpcd_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   // host pins
   input  wire logic        host_select_n_i,
   input  wire logic        data_strobe_a_n_i,
   input  wire logic        data_strobe_b_n_i,
   input  wire logic [1:0]  access_select_i,
   input  wire logic        host_read_write_n_i,
   input  wire logic        halfword_id_i,
   input  wire logic [15:0] host_data_i,
   output logic      [15:0] host_data_o,
   output logic             host_data_oe_o,
   output logic             host_wait_ready_o,
   // read side towards memory
   output logic             rd_req_o,
   output logic      [31:0] rd_addr_o,
   input  wire logic [31:0] rd_word_i,
   input  wire logic        rd_valid_i,
   // write side towards memory
   output logic             wr_valid_o,
   output logic      [31:0] wr_addr_o,
   output logic      [31:0] wr_word_o,
   input  wire logic        wr_ready_i
);

   localparam int FW = hpcd_pkg::ADDR_W + hpcd_pkg::WORD_W;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation and strobe decode

   logic [hpcd_pkg::PIN_W-1:0] pins_s;
   logic        cs_n_s;
   logic        ds_a_s;
   logic        ds_b_s;
   logic [1:0]  sel_s;
   logic        rnw_s;
   logic        hw_s;
   logic [15:0] din_s;
   logic        strobe_on;
   logic        strobe_prev_reg;
   logic        strobe_fall;
   logic        strobe_rise;

   // every pin crosses two flops before use
   hpcd_sync #(
      .WIDTH (hpcd_pkg::PIN_W)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .async_i   ({host_data_i, halfword_id_i, host_read_write_n_i,
                   access_select_i, data_strobe_b_n_i, data_strobe_a_n_i,
                   host_select_n_i}),
      .sync_o    (pins_s)
   );

   assign cs_n_s = pins_s[0];
   assign ds_a_s = pins_s[1];
   assign ds_b_s = pins_s[2];
   assign sel_s  = pins_s[4:3];
   assign rnw_s  = pins_s[5];
   assign hw_s   = pins_s[6];
   assign din_s  = pins_s[22:7];

   // strobe active needs chip select low and one strobe off its rest level
   assign strobe_on   = !cs_n_s && (ds_a_s ^ ds_b_s);
   assign strobe_fall = strobe_on && !strobe_prev_reg;
   assign strobe_rise = !strobe_on && strobe_prev_reg;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strobe_prev_reg <= 1'b0;
      end else begin
         strobe_prev_reg <= strobe_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write buffer towards memory

   hpcd_stream_if #(.WIDTH (FW)) fill_if ();
   hpcd_stream_if #(.WIDTH (FW)) drain_if ();

   hpcd_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .in_port   (fill_if),
      .out_port  (drain_if)
   );

   assign drain_if.ready = wr_ready_i;
   assign wr_valid_o     = drain_if.valid;
   assign wr_addr_o      = drain_if.data[FW-1:hpcd_pkg::WORD_W];
   assign wr_word_o      = drain_if.data[hpcd_pkg::WORD_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // access sequencer and registers

   hpcd_pkg::hpcd_state_type state_reg;
   hpcd_pkg::hpcd_state_type state_next;
   logic [1:0]  sel_reg;
   logic [1:0]  sel_next;
   logic        rnw_reg;
   logic        rnw_next;
   logic        hw_reg;
   logic        hw_next;
   logic        halfword_order_reg;
   logic        halfword_order_next;
   logic        dual_reg;
   logic        dual_next;
   logic        asel_reg;
   logic        asel_next;
   logic [31:0] raddr_reg;
   logic [31:0] raddr_next;
   logic [31:0] waddr_reg;
   logic [31:0] waddr_next;
   logic [15:0] first_half_reg;
   logic [15:0] first_half_next;
   logic [31:0] rd_word_reg;
   logic [31:0] rd_word_next;
   logic [31:0] push_addr_reg;
   logic [31:0] push_addr_next;
   logic [31:0] push_word_reg;
   logic [31:0] push_word_next;
   logic        rdreq_reg;
   logic        rdreq_next;
   logic        rdy_reg;
   logic        rdy_next;
   logic [15:0] dout_reg;
   logic [15:0] dout_next;
   logic        doe_reg;
   logic        doe_next;
   logic [31:0] full_word;
   logic [31:0] addr_word;
   logic [15:0] ctrl_rd;
   logic        is_data_s;
   logic        is_data_reg;

   assign fill_if.valid = (state_reg == hpcd_pkg::ST_PUSH);
   assign fill_if.data  = {push_addr_reg, push_word_reg};
   assign is_data_s     = sel_s[0];    // 0,1 and 1,1 are the data types
   assign is_data_reg   = sel_reg[0];

   // order bit 1 puts the first halfword in the low half
   assign full_word = halfword_order_reg ? {din_s, first_half_reg}
                               : {first_half_reg, din_s};

   // address seen by reads; single mode loads both alike, then each steps on its own accesses
   assign addr_word = (dual_reg && !asel_reg) ? waddr_reg : raddr_reg;

   // order bit mirrored at its status position
   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[hpcd_pkg::HWORD_ORDER_BIT]  = halfword_order_reg;
      ctrl_rd[hpcd_pkg::HWORD_STATUS_BIT] = halfword_order_reg;
      ctrl_rd[hpcd_pkg::DUAL_MODE_BIT]    = dual_reg;
      ctrl_rd[hpcd_pkg::ADDR_SELECT_BIT]  = asel_reg;
   end

   // next state of the sequencer and every register it owns
   always_comb begin
      state_next      = state_reg;
      sel_next        = sel_reg;
      rnw_next        = rnw_reg;
      hw_next         = hw_reg;
      halfword_order_next       = halfword_order_reg;
      dual_next       = dual_reg;
      asel_next       = asel_reg;
      raddr_next      = raddr_reg;
      waddr_next      = waddr_reg;
      first_half_next = first_half_reg;
      rd_word_next    = rd_word_reg;
      push_addr_next  = push_addr_reg;
      push_word_next  = push_word_reg;
      rdreq_next      = 1'b0;
      rdy_next        = rdy_reg;
      case (state_reg)
         hpcd_pkg::ST_IDLE: begin
            if (strobe_fall) begin
               // the whole access runs on these captured levels
               sel_next   = sel_s;
               rnw_next   = rnw_s;
               hw_next    = hw_s;
               state_next = hpcd_pkg::ST_STROBE;
               // a data read fetches its word on the first half only
               if (rnw_s && is_data_s && !hw_s) begin
                  rdreq_next = 1'b1;
                  rdy_next   = 1'b0;
                  state_next = hpcd_pkg::ST_FETCH;
               end
            end
         end
         hpcd_pkg::ST_FETCH: begin
            // an early strobe end aborts with stale data, as the host risked
            if (rd_valid_i || strobe_rise) begin
               rd_word_next = rd_word_i;
               rdy_next     = 1'b1;
               state_next   = strobe_rise ? hpcd_pkg::ST_IDLE
                                          : hpcd_pkg::ST_STROBE;
            end
         end
         hpcd_pkg::ST_STROBE: begin
            if (strobe_rise) begin
               state_next = hpcd_pkg::ST_IDLE;
               if (rnw_reg) begin
                  // read address moves once the pair has used it
                  if (sel_reg == hpcd_pkg::SEL_DATA_INC && hw_reg) begin
                     raddr_next = raddr_reg + 32'h0000_0001;
                  end
               end else begin
                  case (sel_reg)
                     hpcd_pkg::SEL_CONTROL: begin
                        // same register whatever the halfword id
                        halfword_order_next = din_s[hpcd_pkg::HWORD_ORDER_BIT];
                        dual_next = din_s[hpcd_pkg::DUAL_MODE_BIT];
                        asel_next = din_s[hpcd_pkg::ADDR_SELECT_BIT];
                     end
                     hpcd_pkg::SEL_ADDRESS: begin
                        if (!hw_reg) begin
                           first_half_next = din_s;
                        end else begin
                           // commit only on the second half
                           if (!dual_reg || asel_reg) begin
                              raddr_next = full_word;
                           end
                           if (!dual_reg || !asel_reg) begin
                              waddr_next = full_word;
                           end
                        end
                     end
                     default: begin
                        if (!hw_reg) begin
                           first_half_next = din_s;
                        end else begin
                           // whole word goes inward with its address
                           push_word_next = full_word;
                           push_addr_next = waddr_reg;
                           rdy_next       = 1'b0;
                           state_next     = hpcd_pkg::ST_PUSH;
                        end
                     end
                  endcase
               end
            end
         end
         hpcd_pkg::ST_PUSH: begin
            // a full buffer holds the host off through the ready pin
            if (fill_if.ready) begin
               rdy_next   = 1'b1;
               state_next = hpcd_pkg::ST_IDLE;
               if (sel_reg == hpcd_pkg::SEL_DATA_INC) begin
                  waddr_next = waddr_reg + 32'h0000_0001;
               end
               // 1,1 leaves the write address as it was
            end
         end
         default: begin
            state_next = hpcd_pkg::ST_IDLE;
         end
      endcase
   end

   // host read data, driven only while a read strobe is open
   always_comb begin
      dout_next = dout_reg;
      doe_next  = strobe_on && rnw_reg && (state_reg == hpcd_pkg::ST_STROBE);
      if (doe_next) begin
         case (sel_reg)
            hpcd_pkg::SEL_CONTROL: dout_next = ctrl_rd;
            hpcd_pkg::SEL_ADDRESS: begin
               dout_next = (hw_reg == halfword_order_reg) ? addr_word[31:16]
                                                : addr_word[15:0];
            end
            default: begin
               dout_next = (hw_reg == halfword_order_reg) ? rd_word_reg[31:16]
                                                : rd_word_reg[15:0];
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg      <= hpcd_pkg::ST_IDLE;
         sel_reg        <= hpcd_pkg::SEL_CONTROL;
         rnw_reg        <= 1'b1;
         hw_reg         <= 1'b0;
         halfword_order_reg       <= hpcd_pkg::CONTROL_RESET[hpcd_pkg::HWORD_ORDER_BIT];
         dual_reg       <= hpcd_pkg::CONTROL_RESET[hpcd_pkg::DUAL_MODE_BIT];
         asel_reg       <= hpcd_pkg::CONTROL_RESET[hpcd_pkg::ADDR_SELECT_BIT];
         raddr_reg      <= hpcd_pkg::ADDR_RESET;
         waddr_reg      <= hpcd_pkg::ADDR_RESET;
         first_half_reg <= '0;
         rd_word_reg    <= '0;
         push_addr_reg  <= '0;
         push_word_reg  <= '0;
         rdreq_reg      <= 1'b0;
         rdy_reg        <= 1'b1;
         dout_reg       <= '0;
         doe_reg        <= 1'b0;
      end else begin
         state_reg      <= state_next;
         sel_reg        <= sel_next;
         rnw_reg        <= rnw_next;
         hw_reg         <= hw_next;
         halfword_order_reg       <= halfword_order_next;
         dual_reg       <= dual_next;
         asel_reg       <= asel_next;
         raddr_reg      <= raddr_next;
         waddr_reg      <= waddr_next;
         first_half_reg <= first_half_next;
         rd_word_reg    <= rd_word_next;
         push_addr_reg  <= push_addr_next;
         push_word_reg  <= push_word_next;
         rdreq_reg      <= rdreq_next;
         rdy_reg        <= rdy_next;
         dout_reg       <= dout_next;
         doe_reg        <= doe_next;
      end
   end

   assign host_data_o       = dout_reg;
   assign host_data_oe_o    = doe_reg;
   assign host_wait_ready_o = rdy_reg;
   assign rd_req_o          = rdreq_reg;
   assign rd_addr_o         = raddr_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_capture;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_IDLE) && strobe_fall
      |=> (sel_reg == $past(sel_s)) && (rnw_reg == $past(rnw_s))
          && (hw_reg == $past(hw_s));
   endproperty
   a_capture: assert property (p_capture)
      else $error("captured cycle type differs from pins");

   property p_deselect;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_IDLE) && cs_n_s
      |=> (state_reg == hpcd_pkg::ST_IDLE);
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("access started while chip select high");

   property p_ctrl_write;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_STROBE) && strobe_rise && !rnw_reg
      && (sel_reg == hpcd_pkg::SEL_CONTROL)
      |=> (halfword_order_reg == $past(din_s[0])) && (state_reg == hpcd_pkg::ST_IDLE);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control write did not land");

   property p_fix_keeps;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_PUSH) && fill_if.ready
      && (sel_reg == hpcd_pkg::SEL_DATA_FIX)
      |=> $stable(waddr_reg) && $stable(raddr_reg);
   endproperty
   a_fix_keeps: assert property (p_fix_keeps)
      else $error("address moved on non-incrementing access");

   property p_inc_write;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_PUSH) && fill_if.ready
      && (sel_reg == hpcd_pkg::SEL_DATA_INC)
      |=> (waddr_reg == $past(waddr_reg) + 32'h0000_0001) && rdy_reg;
   endproperty
   a_inc_write: assert property (p_inc_write)
      else $error("write address not incremented by one");

   property p_read_fetch;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_IDLE) && strobe_fall && rnw_s
      && is_data_s && !hw_s
      |=> rdreq_reg && !rdy_reg ##1 !rdreq_reg;
   endproperty
   a_read_fetch: assert property (p_read_fetch)
      else $error("data read did not issue one fetch");

   property p_mirror;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      doe_reg && (sel_reg == hpcd_pkg::SEL_CONTROL)
      |-> (dout_reg[0] == dout_reg[8]) && (dout_reg[0] == halfword_order_reg);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("order bit not mirrored at bit 8");

   property p_first_half;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_STROBE) && strobe_rise && !rnw_reg
      && is_data_reg && !hw_reg
      |=> (state_reg == hpcd_pkg::ST_IDLE) && !fill_if.valid;
   endproperty
   a_first_half: assert property (p_first_half)
      else $error("word forwarded after first halfword");

   property p_dual_sel;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_reg == hpcd_pkg::ST_STROBE) && strobe_rise && !rnw_reg
      && (sel_reg == hpcd_pkg::SEL_ADDRESS) && hw_reg && dual_reg
      |=> asel_reg ? $stable(waddr_reg) : $stable(raddr_reg);
   endproperty
   a_dual_sel: assert property (p_dual_sel)
      else $error("dual mode wrote the wrong address register");

endmodule

// >>> test/hpcd_mem_model.sv
module hpcd_mem_model (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   // pacing set by the bench
   input  wire logic        slow_i,
   input  wire logic        stall_i,
   input  wire logic        jitter_i,
   // fetch and store sides
   input  wire logic        rd_req_i,
   input  wire logic [31:0] rd_addr_i,
   output logic      [31:0] rd_word_o,
   output logic             rd_valid_o,
   output logic             wr_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  cnt_reg;
   logic [31:0] addr_reg;
   // content is a scramble of the address; idle bus shows the inverse
   assign rd_word_o  = {32{!rd_valid_o}} ^ addr_reg ^ 32'h5A3C_0F00;
   assign wr_ready_o = !stall_i && jitter_i;
   // answer each fetch after a short or a long wait
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg    <= 4'h0;
         addr_reg   <= 32'h0000_0000;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= (cnt_reg == 4'h1);
         if (rd_req_i) begin
            cnt_reg  <= slow_i ? 4'h9 : 4'h1;
            addr_reg <= rd_addr_i;
         end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end
endmodule

// >>> test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        nrst, cs_n, rw_n, hid, oe, rdy, slow, stall, jit, order;
   logic        rd_req, rd_valid, wr_valid, wr_ready;
   logic [1:0]  sel, ds;
   logic [15:0] hd_i, hd_o;
   logic [31:0] rd_addr, rd_word, wr_addr, wr_word, seed, jit_s, a;
   logic [16:0] got, exp_r;
   logic [16:0] rq[$];
   logic [63:0] wq[$];
   logic [63:0] exp_w;
   int          fail_count, tests_run, cyc;
   event        rd_ev;

   hpcd_host_port u_dut (
      .ref_clk_i(clk), .nrst_i(nrst), .host_select_n_i(cs_n),
      .data_strobe_a_n_i(ds[1]), .data_strobe_b_n_i(ds[0]),
      .access_select_i(sel), .host_read_write_n_i(rw_n),
      .halfword_id_i(hid), .host_data_i(hd_i), .host_data_o(hd_o),
      .host_data_oe_o(oe), .host_wait_ready_o(rdy), .rd_req_o(rd_req),
      .rd_addr_o(rd_addr), .rd_word_i(rd_word), .rd_valid_i(rd_valid),
      .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_word_o(wr_word),
      .wr_ready_i(wr_ready));
   hpcd_mem_model u_mem (
      .ref_clk_i(clk), .nrst_i(nrst), .slow_i(slow), .stall_i(stall),
      .jitter_i(jit), .rd_req_i(rd_req), .rd_addr_i(rd_addr),
      .rd_word_o(rd_word), .rd_valid_o(rd_valid), .wr_ready_o(wr_ready));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic final_report();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and random pacing of the store side
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      #1;
      jit_s = xs(jit_s);
      jit = jit_s[9];
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end

   // results are compared with the oldest note as they appear; the store
   // side is looked at mid-cycle, where valid and ready have settled
   always @(negedge clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
         exp_w = wq.size() > 0 ? wq.pop_front() : 64'h0;
         check({wr_addr, wr_word}, exp_w);
      end
   end
   always @(rd_ev) begin
      exp_r = rq.size() > 0 ? rq.pop_front() : ~got;
      check(got, exp_r);
   end

   ////////////////////////////////////////////////////////////////////////
   // one halfword transfer; the strobe only ends once the port is ready
   task automatic xfer(input logic [1:0] s, input logic r, input logic h,
                       input logic [15:0] d, input logic en);
      while (rdy !== 1'b1) @(posedge clk);
      @(posedge clk);
      #1;
      {sel, rw_n, hid, hd_i, cs_n} = {s, r, h, d, !en};
      repeat (3) @(posedge clk);
      #1;
      seed = xs(seed);
      ds = seed[0] ? 2'b01 : 2'b10;
      repeat (6) @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
      if (r && en) begin
         got = {oe, hd_o};
         ->rd_ev;
      end
      ds = 2'b11;
      repeat (6) @(posedge clk);
      #1;
      {cs_n, hd_i} = {1'b1, ~d};
   endtask

   // two halves in the programmed order, id low then high
   task automatic word_wr(input logic [1:0] s, input logic [31:0] v);
      xfer(s, 1'b0, 1'b0, order ? v[15:0] : v[31:16], 1'b1);
      xfer(s, 1'b0, 1'b1, order ? v[31:16] : v[15:0], 1'b1);
   endtask
   task automatic word_rd(input logic [1:0] s, input logic [31:0] v);
      rq.push_back({1'b1, order ? v[15:0] : v[31:16]});
      rq.push_back({1'b1, order ? v[31:16] : v[15:0]});
      xfer(s, 1'b1, 1'b0, 16'h0000, 1'b1);
      xfer(s, 1'b1, 1'b1, 16'h0000, 1'b1);
   endtask
   task automatic ctl(input logic [15:0] v);
      xfer(hpcd_pkg::SEL_CONTROL, 1'b0, 1'b0, v, 1'b1);
      order = v[0];
   endtask
   // dual control read: both halfword ids must see the same register
   task automatic ctl_rd(input logic [15:0] v);
      rq.push_back({1'b1, v});
      rq.push_back({1'b1, v});
      xfer(hpcd_pkg::SEL_CONTROL, 1'b1, 1'b0, 16'h0000, 1'b1);
      xfer(hpcd_pkg::SEL_CONTROL, 1'b1, 1'b1, 16'h0000, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {nrst, cs_n, ds, sel, rw_n, hid, hd_i} = {1'b0, 1'b1, 2'b11, 20'h0};
      {slow, stall, jit, order, cyc} = 36'h0;
      {seed, jit_s} = {2{32'h4C93_B0B8}};
      repeat (4) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check({oe, rdy, wr_valid}, 3'b010);
      ctl_rd(16'h0000);
      ctl(16'hFFFF);
      ctl_rd(16'h010D);
      xfer(hpcd_pkg::SEL_CONTROL, 1'b0, 1'b0, 16'h0000, 1'b0);
      ctl_rd(16'h010D);
      for (int o = 0; o < 2; o++) begin
         slow = o[0];
         ctl({15'h0000, o[0]});
         ctl_rd({7'h00, o[0], 7'h00, o[0]});
         seed = xs(seed);
         a = seed & 32'h00FF_FFF0;
         word_wr(hpcd_pkg::SEL_ADDRESS, a);
         word_rd(hpcd_pkg::SEL_ADDRESS, a);
         for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            wq.push_back({a + (i > 0), seed});
            word_wr(i == 1 ? 2'h3 : 2'h1, seed);
         end
         word_rd(hpcd_pkg::SEL_DATA_INC, a ^ 32'h5A3C_0F00);
         word_rd(hpcd_pkg::SEL_DATA_FIX, (a + 1) ^ 32'h5A3C_0F00);
         word_rd(hpcd_pkg::SEL_DATA_FIX, (a + 1) ^ 32'h5A3C_0F00);
         ctl(16'h000C | {15'h0000, o[0]});
         word_wr(hpcd_pkg::SEL_ADDRESS, a + 32'h100);
         ctl(16'h0004 | {15'h0000, o[0]});
         word_wr(hpcd_pkg::SEL_ADDRESS, a + 32'h200);
         word_rd(hpcd_pkg::SEL_ADDRESS, a + 32'h200);
         wq.push_back({a + 32'h200, ~a});
         word_wr(hpcd_pkg::SEL_DATA_FIX, ~a);
         word_rd(hpcd_pkg::SEL_DATA_FIX,
                 (a + 32'h100) ^ 32'h5A3C_0F00);
      end
      // store side stalled: 33 words fit, the next one is held off
      stall = 1'b1;
      for (int i = 0; i < 34; i++) begin
         seed = xs(seed);
         wq.push_back({a + 32'h200, seed});
         if (i < 33) word_wr(hpcd_pkg::SEL_DATA_FIX, seed);
      end
      fork
         word_wr(hpcd_pkg::SEL_DATA_FIX, seed);
         begin
            repeat (300) @(posedge clk);
            #1;
            check({wr_valid, rdy}, 2'b10);
            stall = 1'b0;
         end
      join
      repeat (200) @(posedge clk);
      check({wq.size(), rq.size()}, 64'h0);
      final_report();
   end
endmodule
